/* include/adrc_pkg.sv */
// Notes on behaviour
// - bypass selected sends the synchronised receive pin stream straight to the transmit pins.
// - transmit-off forces both transmit pins low, overriding everything else.
// - nine data flows, picked by flow bits together with clock-source bits.
// - converter flows keep separate input and output sample timing domains.
// - PLL reference is either the coded receive stream or the input word clock.
// - an external master clock exists; clock-source bits pick a domain's clock where the flow does not fix it.
// - serial-in converter flow without PLL takes 256 x Fsi on recovered-clock pin.
// - receiver input flows run the input domain on the recovered 256 x Fsi clock.
// - house sync: input on external clock, output domain on recovered clock.
// - receiver-to-serial flow without converter runs wholly on recovered clock.
// - converter delivers 24-bit output samples, masked to the selected output length.
// - full audio band kept when output rate is not below input rate.
// - output slower than input band-limits the input, corner set from ratio.
// - receiver and left-justified serial input treated as 24-bit, no input dither.
// - right-justified serial input into converter truncated to input resolution field.
// - output length 16, 20 or 24; dither scaled, independent per channel.
// - ratio starts at 1:1 and settles well inside the documented bounds.
// - unlock event raised while input rate moves, cleared once it is stable.
// - buffer overflow event raised when a sample arrives with the buffer full and no read in that cycle.
// - ratio readable as 8 bits, 2 integer and 6 fraction bits.
package adrc_pkg;
	localparam int WORD_W = 24;
	localparam int CLOCK_PERIOD_NS = 100;
	localparam int SETTLE_CHANGE_FSO = 9400;
	localparam int SETTLE_POWERUP_FSO = 8300;
	// data flow codes
	localparam logic [3:0] FLOW_SER_PLL = 4'h0;
	localparam logic [3:0] FLOW_SER_EXT256 = 4'h1;
	localparam logic [3:0] FLOW_RX_SRC = 4'h2;
	localparam logic [3:0] FLOW_SER_RXCLK = 4'h3;
	localparam logic [3:0] FLOW_HOUSE = 4'h4;
	localparam logic [3:0] FLOW_RX_SRC_SPLIT = 4'h5;
	localparam logic [3:0] FLOW_RX_NOSRC = 4'h6;
	localparam logic [3:0] FLOW_RX_ONLY = 4'h7;
	localparam logic [3:0] FLOW_TX_ONLY = 4'h8;
	// word length codes, shared by input resolution and output length
	localparam logic [1:0] RES_24 = 2'h0;
	localparam logic [1:0] RES_20 = 2'h1;
	localparam logic [1:0] RES_16 = 2'h2;
	// one sample period is 256 master clock edges
	localparam int MCLK_PER_FS = 256;
	localparam logic [7:0] MCLK_DIV_LAST = 8'hFF;
	localparam int RATIO_INT_BITS = 2;
	localparam int RATIO_FRAC_BITS = 6;
	localparam logic [7:0] RATIO_ONE = 8'h40;
	localparam logic [5:0] WIN_LAST = 6'h3F;
	localparam logic [8:0] CNT_MAX = 9'h0FF;
	localparam logic [7:0] LOCK_TOL = 8'h01;
	localparam logic [23:0] POS_FULL = 24'h7FFFFF;
	localparam logic [15:0] SEED_L = 16'hACE1;
	localparam logic [15:0] SEED_R = 16'h5A3C;
	typedef enum logic [2:0] {
		ST_ACQ = 3'b001,
		ST_TRACK = 3'b010,
		ST_LOCK = 3'b100
	} adrc_lock_t;
	// keeps the upper bits of a word for the chosen length
	function automatic logic [23:0] res_mask(input logic [1:0] res);
		res_mask = (res == RES_16) ? 24'hFFFF00 : (res == RES_20) ? 24'hFFFFF0 : 24'hFFFFFF;
	endfunction: res_mask
	// rectangular dither below the retained lsb
	function automatic logic [23:0] dither_scale(input logic [1:0] res, input logic [15:0] r);
		dither_scale = (res == RES_16) ? {16'h0000, r[7:0]} :
			(res == RES_20) ? {20'h00000, r[3:0]} : 24'h000000;
	endfunction: dither_scale
endpackage: adrc_pkg

/* src/adrc_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module adrc_sync #(
	parameter int W = 4
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level,
	output logic [W-1:0] rise
);
	logic [W-1:0] meta;
	logic [W-1:0] prev;
	// meta feeds level only; edges come from level and prev
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meta <= '0;
			level <= '0;
			prev <= '0;
		end else begin
			meta <= async_in;
			level <= meta;
			prev <= level;
		end
	end
	assign rise = level & ~prev;
endmodule: adrc_sync
`default_nettype wire

/* src/adrc_top.sv */
`timescale 1ns/1ns
`default_nettype none
module adrc_top #(
	parameter int FIFO_DEPTH = 8,
	parameter int FIFO_AW = 3
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic receive_positive_pin,
	input wire logic tx_coded_stream,
	input wire logic coded_stream_bypass,
	input wire logic transmit_drivers_grounded,
	input wire logic [3:0] flow_select,
	input wire logic input_clock_external,
	input wire logic output_clock_external,
	input wire logic pll_ref_word_clock,
	input wire logic input_word_clock,
	input wire logic recovered_master_clock_pin,
	input wire logic external_master_clock_in,
	input wire logic [23:0] serial_left,
	input wire logic [23:0] serial_right,
	input wire logic serial_right_justified,
	input wire logic [1:0] input_resolution_field,
	input wire logic [23:0] rx_left,
	input wire logic [23:0] rx_right,
	input wire logic rx_sample_valid,
	input wire logic [1:0] output_word_length,
	input wire logic output_dither_enable,
	output logic transmit_positive_pin,
	output logic transmit_negative_pin,
	output logic pll_reference,
	output logic [23:0] out_left,
	output logic [23:0] out_right,
	output logic out_valid,
	output logic converter_active,
	output logic rate_unlock_event,
	output logic converter_buffer_overflow,
	output logic [7:0] rate_ratio_value
);
	// pin inputs, all from outside this clock's domain
	logic [3:0] pin_lvl;
	logic [3:0] pin_rise;
	adrc_sync #(.W(4)) u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.async_in({external_master_clock_in, recovered_master_clock_pin,
			input_word_clock, receive_positive_pin}),
		.level(pin_lvl),
		.rise(pin_rise)
	);
	wire rx_lvl = pin_lvl[0];
	wire wclk_lvl = pin_lvl[1];
	wire wclk_rise = pin_rise[1];
	wire rec_rise = pin_rise[2];
	wire ext_rise = pin_rise[3];

	// flow decode; unused codes fall back to the plain transmitter flow
	wire flow_legal = flow_select <= adrc_pkg::FLOW_TX_ONLY;
	wire [3:0] flow = flow_legal ? flow_select : adrc_pkg::FLOW_TX_ONLY;
	wire src_used = flow <= adrc_pkg::FLOW_RX_SRC_SPLIT;
	wire from_rx = (flow == adrc_pkg::FLOW_RX_SRC) || (flow == adrc_pkg::FLOW_RX_SRC_SPLIT) ||
		(flow == adrc_pkg::FLOW_RX_NOSRC) || (flow == adrc_pkg::FLOW_RX_ONLY);
	wire house = flow == adrc_pkg::FLOW_HOUSE;
	wire no_src_rx = (flow == adrc_pkg::FLOW_RX_NOSRC) || (flow == adrc_pkg::FLOW_RX_ONLY);
	// input domain clock: forced where the flow fixes it, else the clock-source bit
	wire in_on_ext = house ? 1'b1 :
		(flow == adrc_pkg::FLOW_SER_EXT256) ? 1'b0 :
		from_rx ? 1'b0 :
		input_clock_external;
	// output domain clock
	wire out_on_ext = house ? 1'b0 :
		no_src_rx ? 1'b0 :
		output_clock_external;
	wire in_mclk_edge = in_on_ext ? ext_rise : rec_rise;
	wire out_mclk_edge = out_on_ext ? ext_rise : rec_rise;

	// sample-rate ticks from the domain master clocks
	logic [7:0] in_div;
	logic [7:0] out_div;
	wire in_tick = in_mclk_edge && (in_div == adrc_pkg::MCLK_DIV_LAST);
	wire out_tick = out_mclk_edge && (out_div == adrc_pkg::MCLK_DIV_LAST);
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			in_div <= 8'h00;
			out_div <= 8'h00;
		end else begin
			if (in_mclk_edge) in_div <= in_div + 8'h01;
			if (out_mclk_edge) out_div <= out_div + 8'h01;
		end
	end

	// input samples; serial data in receiver-clocked flows relies on the source
	// staying locked to the coded stream, nothing here can repair a slip
	wire in_event = from_rx ? rx_sample_valid : wclk_rise;
	wire [23:0] in_mask = (!from_rx && serial_right_justified && src_used) ?
		adrc_pkg::res_mask(input_resolution_field) : 24'hFFFFFF;
	wire [23:0] in_l = (from_rx ? rx_left : serial_left) & in_mask;
	wire [23:0] in_r = (from_rx ? rx_right : serial_right) & in_mask;

	// ratio measurement: input ticks counted over 64 output ticks gives 2.6 format
	logic [5:0] win_cnt;
	logic [8:0] in_cnt;
	adrc_pkg::adrc_lock_t lock_st;
	adrc_pkg::adrc_lock_t next_lock_st;
	wire win_end = out_tick && (win_cnt == adrc_pkg::WIN_LAST);
	wire [8:0] in_cnt_inc = (in_tick && (in_cnt != adrc_pkg::CNT_MAX)) ? in_cnt + 9'h001 : in_cnt;
	wire [7:0] next_ratio = in_cnt_inc[7:0];
	wire [7:0] ratio_diff = (next_ratio > rate_ratio_value) ?
		next_ratio - rate_ratio_value : rate_ratio_value - next_ratio;
	wire ratio_steady = ratio_diff <= adrc_pkg::LOCK_TOL;
	always_comb begin
		next_lock_st = lock_st;
		if (win_end) begin
			unique case (lock_st)
				adrc_pkg::ST_ACQ: next_lock_st = adrc_pkg::ST_TRACK;
				adrc_pkg::ST_TRACK: next_lock_st = ratio_steady ? adrc_pkg::ST_LOCK : adrc_pkg::ST_TRACK;
				adrc_pkg::ST_LOCK: next_lock_st = ratio_steady ? adrc_pkg::ST_LOCK : adrc_pkg::ST_TRACK;
				default: next_lock_st = adrc_pkg::ST_ACQ;
			endcase
		end
	end
	// the ratio has no write path; it only moves at a window's end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			win_cnt <= 6'h00;
			in_cnt <= 9'h000;
			lock_st <= adrc_pkg::ST_ACQ;
			rate_ratio_value <= adrc_pkg::RATIO_ONE;
		end else begin
			lock_st <= next_lock_st;
			if (out_tick) win_cnt <= win_cnt + 6'h01;
			if (win_end) begin
				in_cnt <= 9'h000;
				rate_ratio_value <= next_ratio;
			end else begin
				in_cnt <= in_cnt_inc;
			end
		end
	end
	// unlock stays up through acquisition and tracking; conversion keeps going
	always_ff @(posedge clock) begin
		if (sys_rst) rate_unlock_event <= 1'b1;
		else rate_unlock_event <= next_lock_st != adrc_pkg::ST_LOCK;
	end

	// sample buffer between the input and output sample timing
	logic [47:0] fifo_mem [FIFO_DEPTH];
	logic [FIFO_AW-1:0] wr_ptr;
	logic [FIFO_AW-1:0] rd_ptr;
	logic [FIFO_AW:0] fifo_cnt;
	// the count is one bit wider than the pointers, so full is compared at that width
	localparam logic [FIFO_AW:0] FIFO_FULL_CNT = (FIFO_AW + 1)'(FIFO_DEPTH);
	wire fifo_full = fifo_cnt == FIFO_FULL_CNT;
	wire fifo_empty = fifo_cnt == '0;
	wire pop = src_used && out_tick && !fifo_empty;
	wire push_req = src_used && in_event;
	// a full buffer still accepts when a pop frees a slot in the same cycle
	wire push = push_req && (!fifo_full || pop);
	wire overflow = push_req && fifo_full && !pop;
	wire [FIFO_AW-1:0] wr_next = (wr_ptr == FIFO_AW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
	wire [FIFO_AW-1:0] rd_next = (rd_ptr == FIFO_AW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
	always_ff @(posedge clock) begin
		if (push) fifo_mem[wr_ptr] <= {in_l, in_r};
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fifo_cnt <= '0;
			converter_buffer_overflow <= 1'b0;
		end else begin
			if (push) wr_ptr <= wr_next;
			if (pop) rd_ptr <= rd_next;
			fifo_cnt <= fifo_cnt + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
			converter_buffer_overflow <= overflow;
		end
	end
	wire [47:0] fifo_head = fifo_mem[rd_ptr];

	// per-channel filter, dither and word length; channel 0 left, 1 right
	// an empty buffer repeats the last sample: lower quality, never a glitch
	wire downsampling = rate_ratio_value > adrc_pkg::RATIO_ONE;
	wire [2:0] corner_shift = {1'b0, rate_ratio_value[7:6]} + 3'h1;
	wire [23:0] out_mask = adrc_pkg::res_mask(output_word_length);
	logic [23:0] acc [2];
	logic [23:0] held [2];
	logic [15:0] lfsr [2];
	logic [23:0] next_word [2];
	logic [23:0] pass_word [2];
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			wire [23:0] head = (ch == 0) ? fifo_head[47:24] : fifo_head[23:0];
			wire [23:0] src = pop ? head : held[ch];
			wire signed [24:0] diff = $signed({src[23], src}) - $signed({acc[ch][23], acc[ch]});
			wire signed [24:0] step = diff >>> corner_shift;
			wire [24:0] filt_sum = {acc[ch][23], acc[ch]} + step;
			wire [23:0] filt = downsampling ? filt_sum[23:0] : src;
			wire [23:0] dith = output_dither_enable ?
				adrc_pkg::dither_scale(output_word_length, lfsr[ch]) : 24'h000000;
			wire [24:0] dsum = {filt[23], filt} + {1'b0, dith};
			wire dovf = !filt[23] && dsum[23];
			assign next_word[ch] = (dovf ? adrc_pkg::POS_FULL : dsum[23:0]) & out_mask;
			assign pass_word[ch] = (ch == 0) ? in_l : in_r;
			wire lfsr_fb = lfsr[ch][15] ^ lfsr[ch][13] ^ lfsr[ch][12] ^ lfsr[ch][10];
			// separate seeds keep the two dither streams uncorrelated
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					acc[ch] <= 24'h000000;
					held[ch] <= 24'h000000;
					lfsr[ch] <= (ch == 0) ? adrc_pkg::SEED_L : adrc_pkg::SEED_R;
				end else if (src_used && out_tick) begin
					acc[ch] <= filt;
					held[ch] <= src;
					lfsr[ch] <= {lfsr[ch][14:0], lfsr_fb};
				end
			end
		end
	endgenerate

	// output register: converter words on output ticks, raw words otherwise
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			out_left <= 24'h000000;
			out_right <= 24'h000000;
			out_valid <= 1'b0;
			converter_active <= 1'b0;
		end else begin
			converter_active <= src_used;
			out_valid <= src_used ? out_tick : in_event;
			if (src_used && out_tick) begin
				out_left <= next_word[0];
				out_right <= next_word[1];
			end else if (!src_used && in_event) begin
				out_left <= pass_word[0];
				out_right <= pass_word[1];
			end
		end
	end

	// transmit drivers: grounding beats bypass, bypass beats the encoder
	wire next_tx_p = transmit_drivers_grounded ? 1'b0 :
		coded_stream_bypass ? rx_lvl : tx_coded_stream;
	wire next_tx_n = transmit_drivers_grounded ? 1'b0 :
		coded_stream_bypass ? !rx_lvl : !tx_coded_stream;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			transmit_positive_pin <= 1'b0;
			transmit_negative_pin <= 1'b0;
			pll_reference <= 1'b0;
		end else begin
			transmit_positive_pin <= next_tx_p;
			transmit_negative_pin <= next_tx_n;
			pll_reference <= pll_ref_word_clock ? wclk_lvl : rx_lvl;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_window_done;
		win_end ##1 1'b1;
	endsequence
	sequence s_ratio_moved;
		win_end && !ratio_steady;
	endsequence
	a_bypass_route: assert property (coded_stream_bypass && !transmit_drivers_grounded |=>
		transmit_positive_pin == $past(rx_lvl) && transmit_negative_pin == !$past(rx_lvl))
		else $error("bypass stream not on transmit pins");
	a_tx_grounded: assert property (transmit_drivers_grounded |=>
		!transmit_positive_pin && !transmit_negative_pin)
		else $error("transmit pins not grounded");
	a_house_clocks: assert property (flow_select == adrc_pkg::FLOW_HOUSE |->
		in_mclk_edge == ext_rise && out_mclk_edge == rec_rise)
		else $error("house sync clocking wrong");
	a_nosrc_clock: assert property (flow_select == adrc_pkg::FLOW_RX_NOSRC |->
		!src_used && in_mclk_edge == rec_rise && out_mclk_edge == rec_rise)
		else $error("no-converter flow not on recovered clock");
	a_ratio_start: assert property ($fell(sys_rst) |->
		rate_ratio_value == adrc_pkg::RATIO_ONE && rate_unlock_event)
		else $error("ratio does not start at one");
	a_ratio_hold: assert property (!win_end |=> $stable(rate_ratio_value))
		else $error("ratio moved outside a window end");
	a_ratio_load: assert property (s_window_done |-> rate_ratio_value == $past(next_ratio))
		else $error("ratio not loaded at window end");
	a_unlock_track: assert property (s_ratio_moved |=> rate_unlock_event [*2])
		else $error("unlock not raised on rate change");
	a_ovf_pulse: assert property (push_req && fifo_full && !pop |=>
		converter_buffer_overflow && fifo_full)
		else $error("overflow not flagged");
	a_out_length: assert property (src_used && out_tick &&
		output_word_length == adrc_pkg::RES_16 |=>
		out_valid && out_left[7:0] == 8'h00 && out_right[7:0] == 8'h00)
		else $error("output not cut to 16 bits");

	// further checks on routing, word handling and the measurement
	sequence s_ratio_kept;
		win_end && ratio_steady && lock_st != adrc_pkg::ST_ACQ;
	endsequence
	// transmit pins and reference routing
	a_tx_encoder: assert property (!coded_stream_bypass &&
		!transmit_drivers_grounded |=>
		transmit_positive_pin == $past(tx_coded_stream) &&
		transmit_negative_pin == !$past(tx_coded_stream))
		else $error("encoder stream not on transmit pins");
	a_ref_word: assert property (pll_ref_word_clock |=>
		pll_reference == $past(wclk_lvl))
		else $error("reference is not the word clock");
	a_ref_stream: assert property (!pll_ref_word_clock |=>
		pll_reference == $past(rx_lvl))
		else $error("reference is not the receive stream");
	// clock choice and converter flag per flow
	a_ext256_clock: assert property (flow == adrc_pkg::FLOW_SER_EXT256 |->
		in_mclk_edge == rec_rise)
		else $error("direct clock input not on input domain");
	a_rx_in_clock: assert property (from_rx |-> in_mclk_edge == rec_rise)
		else $error("receiver flow input domain not on recovered clock");
	a_conv_flag: assert property (1'b1 |=> converter_active == $past(src_used))
		else $error("converter flag does not follow the flow");
	// word handling
	a_rx_full_word: assert property (from_rx |->
		in_l == rx_left && in_r == rx_right)
		else $error("receiver word not taken at full width");
	a_in_trunc: assert property (!from_rx && serial_right_justified &&
		src_used && input_resolution_field == adrc_pkg::RES_16 |->
		in_l[7:0] == 8'h00 && in_r[7:0] == 8'h00)
		else $error("right-justified input not truncated");
	a_flat_pass: assert property (pop && !downsampling &&
		output_word_length == adrc_pkg::RES_24 |=>
		out_left == $past(fifo_head[47:24]) && out_right == $past(fifo_head[23:0]))
		else $error("full band word altered");
	a_out_20bit: assert property (src_used && out_tick &&
		output_word_length == adrc_pkg::RES_20 |=>
		out_valid && out_left[3:0] == 4'h0 && out_right[3:0] == 4'h0)
		else $error("output not cut to 20 bits");
	a_pass_valid: assert property (!src_used && in_event |=>
		out_valid && out_left == $past(pass_word[0]) && out_right == $past(pass_word[1]))
		else $error("pass-through word not delivered");
	// buffer and measurement
	a_fifo_bound: assert property (fifo_cnt <= FIFO_FULL_CNT)
		else $error("buffer count past its depth");
	a_ovf_full_only: assert property (!fifo_full |=>
		!converter_buffer_overflow)
		else $error("overflow without a full buffer");
	a_count_sat: assert property (in_cnt <= adrc_pkg::CNT_MAX)
		else $error("input tick count past saturation");
	a_unlock_state: assert property (
		rate_unlock_event == (lock_st != adrc_pkg::ST_LOCK))
		else $error("unlock does not match lock state");
	a_lock_reached: assert property (s_ratio_kept |=> !rate_unlock_event)
		else $error("unlock kept after a steady ratio");
endmodule: adrc_top
`default_nettype wire

/* verification/adrc_far_model.sv */
`timescale 1ns/1ns
`default_nettype none
// far side: stable external clock, recovered 256 x Fsi clock and a serial source locked to it
module adrc_far_model #(
	parameter int EXT_HALF_NS = 200,
	parameter int REC_HALF_NS = 400
) (
	output logic external_master_clock_in,
	output logic recovered_master_clock_pin,
	output logic input_word_clock,
	output logic [23:0] serial_left,
	output logic [23:0] serial_right
);
	int rec_count;
	// free-running stable clock for whichever domain selects it
	initial begin
		external_master_clock_in = 1'b0;
		forever #(EXT_HALF_NS) external_master_clock_in = ~external_master_clock_in;
	end
	// word clock is the recovered clock divided by 256, so data never drifts from it
	initial begin
		recovered_master_clock_pin = 1'b0;
		input_word_clock = 1'b0;
		rec_count = 0;
		serial_left = 24'h000000;
		serial_right = 24'h000000;
		forever begin
			#(REC_HALF_NS) recovered_master_clock_pin = ~recovered_master_clock_pin;
			if (recovered_master_clock_pin) begin
				rec_count = (rec_count + 1) % 256;
				if (rec_count == 0) input_word_clock = 1'b1;
				if (rec_count == 128) begin
					// data changes away from the sampling edge
					input_word_clock = 1'b0;
					serial_left = 24'($urandom);
					serial_right = 24'($urandom);
				end
			end
		end
	end
endmodule: adrc_far_model
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clock, sys_rst, receive_positive_pin, tx_coded_stream, coded_stream_bypass;
	logic transmit_drivers_grounded, input_clock_external, output_clock_external;
	logic pll_ref_word_clock, input_word_clock, recovered_master_clock_pin;
	logic external_master_clock_in, serial_right_justified, rx_sample_valid;
	logic output_dither_enable, transmit_positive_pin, transmit_negative_pin, pll_reference;
	logic out_valid, converter_active, rate_unlock_event, converter_buffer_overflow;
	logic [3:0] flow_select;
	logic [1:0] input_resolution_field, output_word_length;
	logic [23:0] serial_left, serial_right, rx_left, rx_right, out_left, out_right;
	logic [7:0] rate_ratio_value, ratio_seen;
	logic [23:0] exp_l[$];
	logic [23:0] exp_r[$];
	logic [31:0] rnd;
	logic wclk_then;
	int err_count, check_count, n, ovf;
	adrc_top adrc_top_i (.clock(clock), .sys_rst(sys_rst),
		.receive_positive_pin(receive_positive_pin), .tx_coded_stream(tx_coded_stream),
		.coded_stream_bypass(coded_stream_bypass),
		.transmit_drivers_grounded(transmit_drivers_grounded), .flow_select(flow_select),
		.input_clock_external(input_clock_external),
		.output_clock_external(output_clock_external), .pll_ref_word_clock(pll_ref_word_clock),
		.input_word_clock(input_word_clock),
		.recovered_master_clock_pin(recovered_master_clock_pin),
		.external_master_clock_in(external_master_clock_in), .serial_left(serial_left),
		.serial_right(serial_right), .serial_right_justified(serial_right_justified),
		.input_resolution_field(input_resolution_field), .rx_left(rx_left), .rx_right(rx_right),
		.rx_sample_valid(rx_sample_valid), .output_word_length(output_word_length),
		.output_dither_enable(output_dither_enable),
		.transmit_positive_pin(transmit_positive_pin),
		.transmit_negative_pin(transmit_negative_pin), .pll_reference(pll_reference),
		.out_left(out_left), .out_right(out_right), .out_valid(out_valid),
		.converter_active(converter_active), .rate_unlock_event(rate_unlock_event),
		.converter_buffer_overflow(converter_buffer_overflow),
		.rate_ratio_value(rate_ratio_value));
	adrc_far_model adrc_far_model_i (.external_master_clock_in(external_master_clock_in),
		.recovered_master_clock_pin(recovered_master_clock_pin),
		.input_word_clock(input_word_clock), .serial_left(serial_left),
		.serial_right(serial_right));
	// 10 MHz system clock
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask: chk
	task automatic close_out();
		if (err_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask: close_out
	// inputs always move a fixed 10 ns after the rising edge
	task automatic step(input int k);
		repeat (k) @(posedge clock);
		#10;
	endtask: step
	task automatic wait_valid(input int limit);
		int w;
		w = 0;
		while (out_valid !== 1'b1) begin
			step(1);
			w++;
			if (w > limit) begin
				err_count++;
				$display("[ERR] %0t no output sample", $time);
				close_out();
			end
		end
	endtask: wait_valid
	// word kept for a given output length, with dither off
	function automatic logic [23:0] trunc(input logic [23:0] w, input logic [1:0] len);
		trunc = (len == 2'h2) ? (w & 24'hFFFF00) : (len == 2'h1) ? (w & 24'hFFFFF0) : w;
	endfunction: trunc
	initial begin
		{receive_positive_pin, tx_coded_stream, coded_stream_bypass} = 3'h0;
		{transmit_drivers_grounded, input_clock_external, pll_ref_word_clock} = 3'h0;
		{serial_right_justified, rx_sample_valid} = 2'h0;
		output_clock_external = 1'b1;
		output_dither_enable = 1'b1;
		flow_select = adrc_pkg::FLOW_RX_SRC;
		input_resolution_field = adrc_pkg::RES_20;
		output_word_length = adrc_pkg::RES_24;
		{rx_left, rx_right} = 48'h0;
		err_count = 0;
		check_count = 0;
		sys_rst = 1'b1;
		void'($urandom(32'hC37A));
		step(8);
		chk(rate_ratio_value, 24'h000040);
		chk(rate_unlock_event, 24'h000001);
		chk({transmit_positive_pin, out_valid, converter_buffer_overflow}, 24'h0);
		sys_rst = 1'b0;
		// bypass, encoder and grounding; grounding must win
		for (int i = 0; i < 24; i++) begin
			rnd = $urandom;
			receive_positive_pin = rnd[0];
			tx_coded_stream = rnd[3];
			coded_stream_bypass = rnd[2];
			transmit_drivers_grounded = rnd[1];
			serial_right_justified = rnd[4];
			step(4);
			chk(transmit_positive_pin,
				rnd[1] ? 24'h0 : {23'h000000, (rnd[2] ? rnd[0] : rnd[3])});
			chk(transmit_negative_pin,
				rnd[1] ? 24'h0 : {23'h000000, (rnd[2] ? !rnd[0] : !rnd[3])});
		end
		// reference picks the word clock or the coded receive stream
		for (int i = 0; i < 8; i++) begin
			pll_ref_word_clock = i[0];
			wclk_then = input_word_clock;
			step(4);
			if (input_word_clock === wclk_then) begin
				chk(pll_reference, i[0] ? 24'(wclk_then) : 24'(receive_positive_pin));
			end
		end
		// every flow code, out-of-range codes behave as transmit-only
		for (int f = 0; f < 16; f++) begin
			flow_select = 4'(f);
			step(2);
			chk(converter_active, (f < 6) ? 24'h1 : 24'h0);
		end
		// no converter: words pass straight through at full length
		flow_select = adrc_pkg::FLOW_RX_NOSRC;
		for (int i = 0; i < 4; i++) begin
			rnd = $urandom;
			rx_left = rnd[23:0];
			rx_right = ~rnd[23:0];
			rx_sample_valid = 1'b1;
			step(1);
			rx_sample_valid = 1'b0;
			wait_valid(4);
			chk(out_left, rnd[23:0]);
			chk(out_right, ~rnd[23:0]);
			step(1);
		end
		// converter on, each output length with dither off
		flow_select = adrc_pkg::FLOW_RX_SRC;
		output_dither_enable = 1'b0;
		for (int k = 0; k < 3; k++) begin
			output_word_length = 2'(k);
			wait_valid(1500);
			rnd = $urandom;
			rx_left = rnd[23:0];
			rx_right = {rnd[11:0], rnd[23:12]};
			rx_sample_valid = 1'b1;
			step(1);
			rx_sample_valid = 1'b0;
			wait_valid(1500);
			chk(out_left, trunc(rnd[23:0], 2'(k)));
			chk(out_right, trunc({rnd[11:0], rnd[23:12]}, 2'(k)));
			step(1);
		end
		// back-to-back burst of ten into an eight-deep buffer
		output_word_length = adrc_pkg::RES_24;
		output_dither_enable = 1'b1;
		wait_valid(1500);
		ovf = 0;
		rx_sample_valid = 1'b1;
		for (int i = 0; i < 12; i++) begin
			if (i == 10) rx_sample_valid = 1'b0;
			rnd = $urandom;
			rx_left = rnd[23:0];
			rx_right = rnd[31:8];
			if (i < 8) exp_l.push_back(rnd[23:0]);
			if (i < 8) exp_r.push_back(rnd[31:8]);
			step(1);
			if (converter_buffer_overflow === 1'b1) ovf++;
		end
		chk(24'(ovf), 24'h2);
		// drain in order, pairs kept together
		for (int i = 0; i < 8; i++) begin
			step(1);
			wait_valid(1500);
			chk(out_left, exp_l[i]);
			chk(out_right, exp_r[i]);
		end
		// first measurement: recovered clock runs at half the output rate
		n = 0;
		while (rate_ratio_value === 8'h40 && n < 80000) begin
			step(1);
			n++;
		end
		if (n >= 80000) begin
			err_count++;
			$display("[ERR] %0t ratio never measured", $time);
			close_out();
		end
		ratio_seen = rate_ratio_value;
		chk(24'(ratio_seen >= 8'h1E && ratio_seen <= 8'h22), 24'h1);
		chk(rate_unlock_event, 24'h1);
		step(200);
		chk(rate_ratio_value, 24'(ratio_seen));
		// right-justified serial words into the converter keep only their upper 16 bits
		flow_select = adrc_pkg::FLOW_SER_EXT256;
		serial_right_justified = 1'b1;
		input_resolution_field = adrc_pkg::RES_16;
		for (int i = 0; i < 6; i++) begin
			wait_valid(1500);
			// the first ticks may still repeat the last receiver word
			if (i > 2) chk(out_left & 24'h0000FF, 24'h000000);
			if (i > 2) chk(out_right & 24'h0000FF, 24'h000000);
			step(1);
		end
		close_out();
	end
endmodule: tb_top
`default_nettype wire
